// [design/fm_freq_meter.sv]
// Frequency meter with APB register bank
//
// The implementer's own choice: the APB interface to the registers.
`timescale 1ns/1ps
`default_nettype none

// Summary of operation
// - Register bank takes 8, 16, 32-bit accesses
// - Byte and halfword lanes written independently
// - Config writes ignored while meter enabled
// - Enable reads back at once; pending until applied
// - Soft reset restores registers and disables meter
// - Soft reset discards other bits written alongside
// - Soft reset bits stay high until reset completes
// - Start bit one begins a measurement
// - Window is ref_cycle_count reference cycles, non-zero
// - Enable-clear write of one disables done interrupt
// - Enable-set write of one enables done interrupt
// - Done flag sets when busy falls
// - Writing one clears the done flag
// - Overflow bit sticky on value counter overflow
// - Writing one clears the overflow bit
// - Busy reads one while measuring
// - Result in bits 23:0, upper bits zero
// - Count measured periods over the reference window
// - Busy set at start, cleared on completion
// - Interrupt while flag set and enabled
module fm_freq_meter
	import fm_pkg::*;
(
	// APB slave
	input wire logic pclk,
	input wire logic presetn,
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	input wire logic [3:0] pstrb,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// Clocks under measurement, sampled on pclk
	input wire logic measured_clock,
	input wire logic reference_clock_in,
	// Interrupt request
	output logic irq
);

	logic enable_ff;
	logic enable_act_ff;
	fm_sync_t pend_ff;
	logic [2:0] sync_cnt_ff;
	logic [7:0] ref_cycle_count_ff;
	logic irq_en_ff;
	logic done_ff;
	logic oflow_ff;
	fm_state_t state_ff;
	logic busy_q_ff;
	logic [23:0] msr_cnt_ff;
	logic [7:0] ref_cnt_ff;
	logic [23:0] result_ff;
	logic msr_q_ff;
	logic ref_q_ff;
	logic [31:0] prdata_ff;
	logic pslverr_ff;
	logic irq_ff;

	logic wr_en;
	logic setup;
	logic sync_last;
	logic soft_clr;
	logic msr_edge;
	logic ref_edge;
	logic start_go;
	logic busy;
	logic finish;
	logic [23:0] nxt_msr_cnt;
	logic [31:0] nxt_rdata;
	logic nxt_err;
	fm_status_t status;

	// True when lane n of register idx is written this cycle
	function automatic logic wr_hit(input logic [5:0] idx, input int n);
		return wr_en && (paddr[7:2] == idx) && pstrb[n];
	endfunction : wr_hit

	function automatic logic wbit(input int n);
		return pwdata[n];
	endfunction : wbit

	// Zero wait states: every access completes in its first access cycle
	assign pready = 1'b1;
	assign wr_en = psel && penable && pwrite;
	assign setup = psel && !penable;
	assign prdata = prdata_ff;
	assign pslverr = pslverr_ff;
	assign irq = irq_ff;

	assign busy = (state_ff == FM_RUN);
	assign status = '{oflow: oflow_ff, busy: busy};
	assign sync_last = (sync_cnt_ff == FM_SYNC_LAST);
	assign soft_clr = pend_ff.soft_rst && sync_last;
	assign msr_edge = measured_clock && !msr_q_ff;
	assign ref_edge = reference_clock_in && !ref_q_ff;

	// Edge detectors on the measured and reference clocks
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			msr_q_ff <= 1'b0;
			ref_q_ff <= 1'b0;
		end else begin
			msr_q_ff <= measured_clock;
			ref_q_ff <= reference_clock_in;
		end
	end

	// Enable and soft reset write synchronisation
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable_ff <= 1'b0;
			pend_ff <= '0;
			sync_cnt_ff <= FM_SYNC_IDLE;
		end else if (soft_clr) begin
			enable_ff <= 1'b0;
			pend_ff <= '0;
			sync_cnt_ff <= FM_SYNC_IDLE;
		end else if (wr_hit(FM_CTRL_IDX, FM_LANE0) && !pend_ff.soft_rst) begin
			if (wbit(FM_SOFT_RST_BIT)) begin
				// Enable bit of the same write is dropped
				pend_ff.soft_rst <= 1'b1;
				sync_cnt_ff <= FM_SYNC_CYCLES;
			end else begin
				enable_ff <= wbit(FM_ENABLE_BIT);
				pend_ff.enable <= 1'b1;
				sync_cnt_ff <= FM_SYNC_CYCLES;
			end
		end else if (sync_cnt_ff != FM_SYNC_IDLE) begin
			sync_cnt_ff <= sync_cnt_ff - FM_SYNC_LAST;
			if (sync_last) begin
				pend_ff.enable <= 1'b0;
			end
		end
	end

	// Enable as seen by the measurement logic, applied after sync
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			enable_act_ff <= 1'b0;
		end else if (soft_clr) begin
			enable_act_ff <= 1'b0;
		end else if (pend_ff.enable && sync_last) begin
			enable_act_ff <= enable_ff;
		end
	end

	// Configuration is enable-protected
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			ref_cycle_count_ff <= FM_REF_RST;
		end else if (soft_clr) begin
			ref_cycle_count_ff <= FM_REF_RST;
		end else if (wr_hit(FM_CFG_IDX, FM_LANE0) && !enable_ff &&
				!enable_act_ff) begin
			ref_cycle_count_ff <= pwdata[FM_REF_W-1:0];
		end
	end

	// Done interrupt enable, set and clear through separate registers
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_en_ff <= 1'b0;
		end else if (soft_clr) begin
			irq_en_ff <= 1'b0;
		end else if (wr_hit(FM_IESET_IDX, FM_LANE0) && wbit(FM_DONE_BIT)) begin
			irq_en_ff <= 1'b1;
		end else if (wr_hit(FM_IECLR_IDX, FM_LANE0) && wbit(FM_DONE_BIT)) begin
			irq_en_ff <= 1'b0;
		end
	end

	// Start is taken only when enabled, idle and not in soft reset
	assign start_go = wr_hit(FM_CMD_IDX, FM_LANE0) && wbit(FM_START_BIT) &&
		enable_act_ff && !busy && !pend_ff.soft_rst;
	assign finish = busy && ref_edge &&
		(ref_cnt_ff + FM_REF_ONE == ref_cycle_count_ff);

	always_comb begin
		nxt_msr_cnt = msr_cnt_ff;
		if (msr_edge) begin
			nxt_msr_cnt = msr_cnt_ff + FM_RES_ONE;
		end
	end

	// Measurement state machine
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			state_ff <= FM_IDLE;
			msr_cnt_ff <= FM_RES_RST;
			ref_cnt_ff <= FM_REF_RST;
		end else if (soft_clr) begin
			state_ff <= FM_IDLE;
			msr_cnt_ff <= FM_RES_RST;
			ref_cnt_ff <= FM_REF_RST;
		end else begin
			case (state_ff)
				FM_IDLE: begin
					if (start_go) begin
						state_ff <= FM_RUN;
						msr_cnt_ff <= FM_RES_RST;
						ref_cnt_ff <= FM_REF_RST;
					end
				end
				FM_RUN: begin
					// Disabling mid-window abandons the measurement
					if (!enable_act_ff || finish) begin
						state_ff <= FM_IDLE;
					end
					msr_cnt_ff <= nxt_msr_cnt;
					if (ref_edge) begin
						ref_cnt_ff <= ref_cnt_ff + FM_REF_ONE;
					end
				end
				default: begin
					state_ff <= FM_IDLE;
				end
			endcase
		end
	end

	// Result captured at the end of a full window only
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			result_ff <= FM_RES_RST;
		end else if (soft_clr) begin
			result_ff <= FM_RES_RST;
		end else if (finish && enable_act_ff) begin
			result_ff <= nxt_msr_cnt;
		end
	end

	// Sticky overflow; a set in the clearing cycle wins
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			oflow_ff <= 1'b0;
		end else if (soft_clr) begin
			oflow_ff <= 1'b0;
		end else if (busy && msr_edge && msr_cnt_ff == FM_RES_MAX) begin
			oflow_ff <= 1'b1;
		end else if (wr_hit(FM_STAT_IDX, FM_LANE0) && wbit(FM_OFLOW_BIT)) begin
			oflow_ff <= 1'b0;
		end
	end

	// Done flag on the falling edge of busy; set wins over clear
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			busy_q_ff <= 1'b0;
			done_ff <= 1'b0;
		end else if (soft_clr) begin
			busy_q_ff <= 1'b0;
			done_ff <= 1'b0;
		end else begin
			busy_q_ff <= busy;
			if (busy_q_ff && !busy) begin
				done_ff <= 1'b1;
			end else if (wr_hit(FM_FLAG_IDX, FM_LANE0) && wbit(FM_DONE_BIT)) begin
				done_ff <= 1'b0;
			end
		end
	end

	// Interrupt request, registered
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			irq_ff <= 1'b0;
		end else begin
			irq_ff <= done_ff && irq_en_ff && !soft_clr;
		end
	end

	// Read mux; narrow registers sit in low bits, the rest reads zero
	always_comb begin
		nxt_rdata = FM_ZERO32;
		nxt_err = 1'b0;
		case (paddr[7:2])
			FM_CTRL_IDX: begin
				nxt_rdata[FM_SOFT_RST_BIT] = pend_ff.soft_rst;
				nxt_rdata[FM_ENABLE_BIT] = enable_ff;
			end
			FM_CMD_IDX: begin
				nxt_rdata = FM_ZERO32;
			end
			FM_CFG_IDX: begin
				nxt_rdata[FM_REF_W-1:0] = ref_cycle_count_ff;
			end
			FM_IECLR_IDX, FM_IESET_IDX: begin
				nxt_rdata[FM_DONE_BIT] = irq_en_ff;
			end
			FM_FLAG_IDX: begin
				nxt_rdata[FM_DONE_BIT] = done_ff;
			end
			FM_STAT_IDX: begin
				nxt_rdata[FM_BUSY_BIT] = status.busy;
				nxt_rdata[FM_OFLOW_BIT] = status.oflow;
			end
			FM_SYNC_IDX: begin
				nxt_rdata[FM_SOFT_RST_BIT] = pend_ff.soft_rst;
				nxt_rdata[FM_ENABLE_BIT] = pend_ff.enable;
			end
			FM_RES_IDX: begin
				nxt_rdata[FM_RES_W-1:0] = result_ff;
			end
			default: begin
				nxt_err = 1'b1;
			end
		endcase
	end

	// Read data and error sampled in the setup cycle, shown in access
	always_ff @(posedge pclk or negedge presetn) begin
		if (!presetn) begin
			prdata_ff <= FM_ZERO32;
			pslverr_ff <= 1'b0;
		end else if (setup) begin
			prdata_ff <= pwrite ? FM_ZERO32 : nxt_rdata;
			pslverr_ff <= nxt_err;
		end else if (!psel) begin
			pslverr_ff <= 1'b0;
		end
	end

	default clocking fm_cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);

	a_enable_readback: assert property (
		wr_hit(FM_CTRL_IDX, FM_LANE0) && !wbit(FM_SOFT_RST_BIT) &&
		!pend_ff.soft_rst |=> enable_ff == $past(pwdata[FM_ENABLE_BIT])
			&& pend_ff.enable)
		else $error("enable not read back at once");

	a_sync_bounded: assert property (
		$rose(pend_ff.enable) && !pend_ff.soft_rst |-> ##[1:8] !pend_ff.enable)
		else $error("enable sync pending too long");

	a_soft_rst_discard: assert property (
		wr_hit(FM_CTRL_IDX, FM_LANE0) && wbit(FM_SOFT_RST_BIT) &&
		!pend_ff.soft_rst |=> $stable(enable_ff) && pend_ff.soft_rst)
		else $error("soft reset write changed enable");

	a_soft_rst_clears: assert property (
		soft_clr |=> !enable_ff && !enable_act_ff && !pend_ff.soft_rst &&
			result_ff == FM_RES_RST && !done_ff)
		else $error("soft reset did not restore state");

	a_cfg_protect: assert property (
		enable_ff && !soft_clr |=> $stable(ref_cycle_count_ff))
		else $error("config changed while enabled");

	a_start_busy: assert property (
		start_go |=> busy)
		else $error("start did not set busy");

	a_start_ignored: assert property (
		wr_hit(FM_CMD_IDX, FM_LANE0) && !enable_act_ff && !busy
		&& !soft_clr |=> !busy && $stable(result_ff))
		else $error("start accepted while disabled");

	a_done_on_fall: assert property (
		busy_q_ff && !busy && !soft_clr |=> done_ff)
		else $error("done flag missed busy fall");

	a_done_w1c: assert property (
		done_ff && wr_hit(FM_FLAG_IDX, FM_LANE0) && wbit(FM_DONE_BIT) &&
		!(busy_q_ff && !busy) && !soft_clr |=> !done_ff)
		else $error("done flag not cleared");

	a_oflow_sticky: assert property (
		oflow_ff && !soft_clr &&
		!(wr_hit(FM_STAT_IDX, FM_LANE0) && wbit(FM_OFLOW_BIT)) |=> oflow_ff)
		else $error("overflow bit dropped by itself");

	a_irq_follow: assert property (
		done_ff && irq_en_ff && !soft_clr |=> irq)
		else $error("interrupt not raised");

	a_irq_drop: assert property (
		!done_ff || !irq_en_ff |=> !irq)
		else $error("interrupt raised without cause");

	a_result_high: assert property (
		psel && penable && !pwrite && paddr[7:2] == FM_RES_IDX
		|-> prdata[31:FM_RES_W] == '0)
		else $error("result upper bits not zero");

endmodule : fm_freq_meter

`default_nettype wire

// [design/fm_pkg.sv]
// Constants and types shared by the frequency meter
package fm_pkg;
	// Register indices; byte address is four times the index
	localparam logic [5:0] FM_CTRL_IDX = 6'h00;
	localparam logic [5:0] FM_CMD_IDX = 6'h01;
	localparam logic [5:0] FM_CFG_IDX = 6'h02;
	localparam logic [5:0] FM_IECLR_IDX = 6'h08;
	localparam logic [5:0] FM_IESET_IDX = 6'h09;
	localparam logic [5:0] FM_FLAG_IDX = 6'h0a;
	localparam logic [5:0] FM_STAT_IDX = 6'h0b;
	localparam logic [5:0] FM_SYNC_IDX = 6'h0c;
	localparam logic [5:0] FM_RES_IDX = 6'h10;
	// Field positions
	localparam int FM_SOFT_RST_BIT = 0;
	localparam int FM_ENABLE_BIT = 1;
	localparam int FM_START_BIT = 0;
	localparam int FM_DONE_BIT = 0;
	localparam int FM_BUSY_BIT = 0;
	localparam int FM_OFLOW_BIT = 1;
	localparam int FM_LANE0 = 0;
	localparam int FM_LANE1 = 1;
	localparam int FM_REF_W = 8;
	localparam int FM_RES_W = 24;
	// Reset values, counter limit and increments
	localparam logic [7:0] FM_REF_RST = 8'h00;
	localparam logic [23:0] FM_RES_RST = 24'h000000;
	localparam logic [31:0] FM_ZERO32 = 32'h00000000;
	localparam logic [23:0] FM_RES_MAX = 24'hffffff;
	localparam logic [23:0] FM_RES_ONE = 24'h000001;
	localparam logic [7:0] FM_REF_ONE = 8'h01;
	// Write synchronisation delay in pclk cycles
	localparam logic [2:0] FM_SYNC_CYCLES = 3'h3;
	localparam logic [2:0] FM_SYNC_LAST = 3'h1;
	localparam logic [2:0] FM_SYNC_IDLE = 3'h0;

	typedef enum logic [1:0] {
		FM_IDLE = 2'b01,
		FM_RUN = 2'b10
	} fm_state_t;

	typedef struct packed {
		logic oflow;
		logic busy;
	} fm_status_t;

	typedef struct packed {
		logic enable;
		logic soft_rst;
	} fm_sync_t;
endpackage : fm_pkg

// [sim/fm_freq_meter_test.sv]
// Self-checking bench for the frequency meter and its APB register bank
`timescale 1ns/1ps
`default_nettype none

module fm_freq_meter_test
	import fm_pkg::*;
;
	logic pclk = 1'b0;
	logic presetn = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h00000000;
	logic [3:0] pstrb = 4'h0;
	logic [31:0] prdata;
	logic pready;
	logic pslverr;
	logic msr = 1'b0;
	logic ref_in = 1'b0;
	logic irq;
	logic [31:0] rd;
	logic err;
	int n_fail = 0;
	int n_tests = 0;
	logic [7:0] adr [9] = '{8'h00, 8'h04, 8'h08, 8'h20, 8'h24, 8'h28, 8'h2c,
		8'h30, 8'h40};
	logic [7:0] rv [2] = '{8'h01, 8'hff};
	logic [31:0] nm [2] = '{32'h00000007, 32'h00000002};

	fm_freq_meter DUT (
		.pclk(pclk),
		.presetn(presetn),
		.psel(psel),
		.penable(penable),
		.pwrite(pwrite),
		.paddr(paddr),
		.pwdata(pwdata),
		.pstrb(pstrb),
		.prdata(prdata),
		.pready(pready),
		.pslverr(pslverr),
		.measured_clock(msr),
		.reference_clock_in(ref_in),
		.irq(irq)
	);

	always #10 pclk = ~pclk;

	task finish_test();
		$display("Comparisons %0d, mismatches %0d", n_tests, n_fail);
		if (n_fail == 0 && n_tests > 0) begin
			$display("Regression OK");
		end else begin
			$display("Regression broken");
		end
		$finish;
	endtask : finish_test

	task chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp) begin
			n_fail++;
			$display("Error at %0t: got %h expected %h", $time, got, exp);
		end
	endtask : chk

	// One transfer; an idle edge follows so the next setup never overlaps
	task apb(input logic w, input logic [7:0] a, input logic [31:0] d,
		input logic [3:0] s);
		int i;
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		pstrb <= s;
		@(posedge pclk);
		penable <= 1'b1;
		i = 0;
		do begin
			@(posedge pclk);
			i++;
		end while (pready !== 1'b1 && i < 50);
		rd = prdata;
		err = pslverr;
		psel <= 1'b0;
		penable <= 1'b0;
		if (i >= 50) begin
			n_fail++;
			finish_test();
		end
		@(posedge pclk);
	endtask : apb

	task wr(input logic [7:0] a, input logic [31:0] d);
		apb(1'b1, a, d, 4'hf);
	endtask : wr

	task rdc(input logic [7:0] a, input logic [31:0] exp);
		apb(1'b0, a, 32'h00000000, 4'h0);
		chk(rd, exp);
	endtask : rdc

	task poll(input logic [7:0] a, input logic [31:0] m);
		int k;
		k = 0;
		do begin
			apb(1'b0, a, 32'h00000000, 4'h0);
			k++;
		end while ((rd & m) !== 32'h00000000 && k < 200);
		if (k >= 200) begin
			n_fail++;
			finish_test();
		end
	endtask : poll

	// All measured edges land before each reference edge, so count is exact
	task gen(input logic [7:0] nr, input logic [31:0] nmsr);
		repeat (nr) begin
			repeat (nmsr) begin
				msr <= 1'b1;
				repeat (2) @(posedge pclk);
				msr <= 1'b0;
				repeat (2) @(posedge pclk);
			end
			ref_in <= 1'b1;
			repeat (2) @(posedge pclk);
			ref_in <= 1'b0;
			repeat (2) @(posedge pclk);
		end
	endtask : gen

	initial begin
		repeat (2) @(posedge pclk);
		presetn <= 1'b1;
		@(posedge pclk);
		foreach (adr[k]) begin
			rdc(adr[k], 32'h00000000);
		end
		apb(1'b0, 8'h14, 32'h00000000, 4'h0);
		chk({31'h0, err}, 32'h00000001);
		chk(rd, 32'h00000000);
		apb(1'b1, 8'h08, 32'h0000aa55, 4'h2);
		rdc(8'h08, 32'h00000000);
		apb(1'b1, 8'h08, 32'h0000aa55, 4'h1);
		rdc(8'h08, 32'h00000055);
		$display("Test reset and lanes done");
		for (int j = 0; j < 2; j++) begin
			wr(8'h00, 32'h00000000);
			poll(8'h30, 32'h00000003);
			wr(8'h08, {24'h0, rv[j]});
			rdc(8'h08, {24'h0, rv[j]});
			wr(8'h00, 32'h00000002);
			rdc(8'h30, 32'h00000002);
			rdc(8'h00, 32'h00000002);
			poll(8'h30, 32'h00000002);
			wr(8'h08, 32'h00000000);
			rdc(8'h08, {24'h0, rv[j]});
			wr(8'h24, 32'h00000001);
			rdc(8'h20, 32'h00000001);
			wr(8'h04, 32'h00000001);
			rdc(8'h2c, 32'h00000001);
			gen(rv[j], nm[j]);
			poll(8'h2c, 32'h00000001);
			rdc(8'h40, {24'h0, rv[j]} * nm[j]);
			rdc(8'h2c, 32'h00000000);
			rdc(8'h28, 32'h00000001);
			chk({31'h0, irq}, 32'h00000001);
			wr(8'h28, 32'h00000000);
			rdc(8'h28, 32'h00000001);
			wr(8'h28, 32'h00000001);
			rdc(8'h28, 32'h00000000);
			chk({31'h0, irq}, 32'h00000000);
			$display("Test measurement %0d done", j);
		end
		wr(8'h20, 32'h00000001);
		rdc(8'h24, 32'h00000000);
		wr(8'h24, 32'h00000001);
		wr(8'h00, 32'h00000000);
		poll(8'h30, 32'h00000003);
		wr(8'h00, 32'h00000003);
		rdc(8'h00, 32'h00000001);
		poll(8'h00, 32'h00000001);
		rdc(8'h00, 32'h00000000);
		rdc(8'h24, 32'h00000000);
		rdc(8'h40, 32'h00000000);
		rdc(8'h08, 32'h00000000);
		wr(8'h04, 32'h00000001);
		rdc(8'h2c, 32'h00000000);
		wr(8'h2c, 32'h00000002);
		rdc(8'h2c, 32'h00000000);
		$display("Test soft reset done");
		finish_test();
	end
endmodule : fm_freq_meter_test

`default_nettype wire
